// ### common/mcpwm_pkg.sv
// Purpose: shared constants and types of the multi channel pwm unit
// Assumes: byte wide register port, one 200 MHz clock
// Notes: offsets are the byte addresses of the register port
`default_nettype none
package mcpwm_pkg;
	localparam int MCPWM_ADDR_W = 8;
	localparam int MCPWM_DATA_W = 8;
	localparam int MCPWM_CNT_W = 16;
	localparam int MCPWM_NCH = 4;

	// -------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------
	localparam logic [7:0] OFF_SA_LOW_LO = 8'h99;
	localparam logic [7:0] OFF_SA_LOW_HI = 8'h9a;
	localparam logic [7:0] OFF_SA_HIGH_LO = 8'h9b;
	localparam logic [7:0] OFF_SA_HIGH_HI = 8'h9c;
	localparam logic [7:0] OFF_SB_LOW_LO = 8'h9d;
	localparam logic [7:0] OFF_SB_LOW_HI = 8'h9e;
	localparam logic [7:0] OFF_SB_HIGH_LO = 8'h9f;
	localparam logic [7:0] OFF_SB_HIGH_HI = 8'ha1;
	localparam logic [7:0] OFF_GEN_CTRL = 8'ha2;
	localparam logic [7:0] OFF_CH_CTRL = 8'ha3;
	localparam logic [7:0] OFF_CH0_CMP_LO = 8'ha4;
	localparam logic [7:0] OFF_CH0_CMP_HI = 8'ha5;
	localparam logic [7:0] OFF_CH1_CMP_LO = 8'ha6;
	localparam logic [7:0] OFF_CH1_CMP_HI = 8'ha7;
	localparam logic [7:0] OFF_CH2_CMP_LO = 8'ha9;
	localparam logic [7:0] OFF_CH2_CMP_HI = 8'haa;
	localparam logic [7:0] OFF_CH3_CMP_LO = 8'hab;
	localparam logic [7:0] OFF_CH3_CMP_HI = 8'hac;
	localparam logic [7:0] OFF_CYCLE_LO = 8'had;
	localparam logic [7:0] OFF_CYCLE_HI = 8'hae;
	localparam logic [7:0] OFF_STATUS = 8'hbe;

	// -------------------------------------------------------------
	// field positions and reset values
	// -------------------------------------------------------------
	localparam int BIT_QUAD_EN = 0;
	localparam int BIT_SA_EN = 1;
	localparam int BIT_SB_EN = 2;
	localparam int BIT_SRC_CH1 = 3;
	localparam int BIT_SRC_CH2 = 4;
	localparam int BIT_SRC_CH3 = 5;
	localparam int POL_LSB = 4;
	localparam int CHEN_LSB = 0;
	localparam logic [7:0] GEN_CTRL_MASK = 8'h3f;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mcpwm_req_t;

	typedef enum logic [0:0] {
		MCPWM_PH_LOW = 1'b0,
		MCPWM_PH_HIGH = 1'b1
	} mcpwm_phase_t;
endpackage : mcpwm_pkg
`default_nettype wire

// ### src/mcpwm_single.sv
// Purpose: single channel generator with separate high and low times
// Assumes: times are counts of sys_clk cycles
// Notes: a zero length phase is skipped in one cycle, output masked
`default_nettype none
module mcpwm_single (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// settings
	input wire logic enable,
	input wire logic [mcpwm_pkg::MCPWM_CNT_W-1:0] high_time,
	input wire logic [mcpwm_pkg::MCPWM_CNT_W-1:0] low_time,
	// output
	output logic pwm_out
);
	import mcpwm_pkg::*;

	mcpwm_phase_t phase;
	logic [MCPWM_CNT_W-1:0] cnt;
	logic [MCPWM_CNT_W:0] next_cnt;
	logic [MCPWM_CNT_W-1:0] limit;
	logic phase_done;

	always_comb begin
		next_cnt = {1'b0, cnt} + 17'h0_0001;
		limit = (phase == MCPWM_PH_HIGH) ? high_time : low_time;
		phase_done = (next_cnt >= {1'b0, limit});
	end

	// -------------------------------------------------------------
	// phase sequencer
	// -------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst || !enable) begin
			phase <= MCPWM_PH_HIGH;
			cnt <= WORD_RST;
		end else if (phase_done) begin
			cnt <= WORD_RST;
			case (phase)
				MCPWM_PH_HIGH: phase <= MCPWM_PH_LOW;
				MCPWM_PH_LOW: phase <= MCPWM_PH_HIGH;
				default: phase <= MCPWM_PH_HIGH;
			endcase
		end else begin
			cnt <= next_cnt[MCPWM_CNT_W-1:0];
		end
	end

	// zero low time means a steady high level, not a one cycle glitch
	always_ff @(posedge sys_clk) begin
		if (rst || !enable) begin
			pwm_out <= 1'b0;
		end else if (phase == MCPWM_PH_HIGH) begin
			pwm_out <= (high_time != WORD_RST);
		end else begin
			pwm_out <= (low_time == WORD_RST) && (high_time != WORD_RST);
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_enter_high;
		enable && phase == MCPWM_PH_LOW && phase_done && high_time == 16'h0002;
	endsequence

	// setting must stay put while the two high cycles are launched
	sequence s_keep_high;
		(enable && high_time == 16'h0002) [*2];
	endsequence

	a_single_off_low: assert property (!enable |=> !pwm_out)
		else $error("single generator output active while disabled");
	a_single_high_len: assert property (s_enter_high ##1 s_keep_high |-> pwm_out [*2])
		else $error("single generator high time not kept");
endmodule : mcpwm_single
`default_nettype wire

// ### src/mcpwm_top.sv
// Purpose: multi channel pwm unit, one four channel and two single generators
// Assumes: byte register port, read data one cycle after the read strobe
// Notes: outputs are registered; quad levels lag their counter by a cycle, single levels by two
// Function
// - control bits 0,1,2 enable quad, single a, single b generators.
// - control bit 3 makes channel 1 use channel 0 compare value.
// - control bit 4 makes channel 2 use channel 0 compare value.
// - control bit 5 makes channel 3 use channel 0 compare value.
// - polarity bits 7..4 choose low or high after count passes compare.
// - channel control bits 3..0 gate each quad channel output.
// - channel 0 compare is a 16-bit value from two byte registers.
// - channel 1 compare from two bytes resetting to zero.
// - channel 2 compare from two bytes resetting to zero.
// - single b low time is 16 bits, two byte registers.
// - single b high time is 16 bits, two bytes, reset zero.
// - single a holds 16-bit low and high times, byte registers.
// - shared quad period from a 16-bit cycle value in two bytes.
// - channel 3 compare from its own two byte registers.
//
// Design decision made here: the address-and-strobe port.
`default_nettype none
module mcpwm_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port
	input wire mcpwm_pkg::mcpwm_req_t req,
	output logic [mcpwm_pkg::MCPWM_DATA_W-1:0] rd_data,
	// pwm outputs
	output logic [mcpwm_pkg::MCPWM_NCH-1:0] quad_out,
	output logic single_a_out,
	output logic single_b_out
);
	import mcpwm_pkg::*;

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic [MCPWM_CNT_W-1:0] duty_sel(
		input logic use_ch0,
		input logic [MCPWM_CNT_W-1:0] own,
		input logic [MCPWM_CNT_W-1:0] ch0
	);
		duty_sel = use_ch0 ? ch0 : own;
	endfunction : duty_sel

	// level of a channel for a given count; pol 1 drops after the pass
	function automatic logic chan_level(
		input logic pol,
		input logic [MCPWM_CNT_W-1:0] count,
		input logic [MCPWM_CNT_W-1:0] cmp_val
	);
		chan_level = pol ? (count < cmp_val) : (count >= cmp_val);
	endfunction : chan_level

	// -------------------------------------------------------------
	// register storage
	// -------------------------------------------------------------
	logic [7:0] gen_ctrl;
	logic [7:0] ch_ctrl;
	logic [MCPWM_CNT_W-1:0] cmp [MCPWM_NCH];
	logic [MCPWM_CNT_W-1:0] cycle_value;
	logic [MCPWM_CNT_W-1:0] sa_low_time;
	logic [MCPWM_CNT_W-1:0] sa_high_time;
	logic [MCPWM_CNT_W-1:0] sb_low_time;
	logic [MCPWM_CNT_W-1:0] sb_high_time;

	logic [MCPWM_CNT_W-1:0] quad_cnt;
	logic [MCPWM_CNT_W-1:0] eff_cmp [MCPWM_NCH];
	logic [MCPWM_CNT_W:0] next_quad_cnt;
	logic sa_level;
	logic sb_level;

	// -------------------------------------------------------------
	// register writes
	// -------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gen_ctrl <= BYTE_RST;
			ch_ctrl <= BYTE_RST;
			cycle_value <= WORD_RST;
			for (int i = 0; i < MCPWM_NCH; i++) begin
				cmp[i] <= WORD_RST;
			end
		end else if (req.wr) begin
			case (req.addr)
				OFF_GEN_CTRL: begin
					// top two bits have no function and hold zero
					gen_ctrl <= req.wdata & GEN_CTRL_MASK;
				end
				OFF_CH_CTRL: begin
					ch_ctrl <= req.wdata;
				end
				OFF_CH0_CMP_LO: begin
					cmp[0][7:0] <= req.wdata;
				end
				OFF_CH0_CMP_HI: begin
					cmp[0][15:8] <= req.wdata;
				end
				OFF_CH1_CMP_LO: begin
					cmp[1][7:0] <= req.wdata;
				end
				OFF_CH1_CMP_HI: begin
					cmp[1][15:8] <= req.wdata;
				end
				OFF_CH2_CMP_LO: begin
					cmp[2][7:0] <= req.wdata;
				end
				OFF_CH2_CMP_HI: begin
					cmp[2][15:8] <= req.wdata;
				end
				OFF_CH3_CMP_LO: begin
					cmp[3][7:0] <= req.wdata;
				end
				OFF_CH3_CMP_HI: begin
					cmp[3][15:8] <= req.wdata;
				end
				OFF_CYCLE_LO: begin
					cycle_value[7:0] <= req.wdata;
				end
				OFF_CYCLE_HI: begin
					cycle_value[15:8] <= req.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// single generator time settings kept apart from the quad block
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sa_low_time <= WORD_RST;
			sa_high_time <= WORD_RST;
			sb_low_time <= WORD_RST;
			sb_high_time <= WORD_RST;
		end else if (req.wr) begin
			case (req.addr)
				OFF_SA_LOW_LO: begin
					sa_low_time[7:0] <= req.wdata;
				end
				OFF_SA_LOW_HI: begin
					sa_low_time[15:8] <= req.wdata;
				end
				OFF_SA_HIGH_LO: begin
					sa_high_time[7:0] <= req.wdata;
				end
				OFF_SA_HIGH_HI: begin
					sa_high_time[15:8] <= req.wdata;
				end
				OFF_SB_LOW_LO: begin
					sb_low_time[7:0] <= req.wdata;
				end
				OFF_SB_LOW_HI: begin
					sb_low_time[15:8] <= req.wdata;
				end
				OFF_SB_HIGH_LO: begin
					sb_high_time[7:0] <= req.wdata;
				end
				OFF_SB_HIGH_HI: begin
					sb_high_time[15:8] <= req.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// -------------------------------------------------------------
	// register reads
	// -------------------------------------------------------------
	// data stands only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk) begin
		if (rst || !req.rd) begin
			rd_data <= BYTE_RST;
		end else begin
			case (req.addr)
				OFF_SA_LOW_LO: rd_data <= sa_low_time[7:0];
				OFF_SA_LOW_HI: rd_data <= sa_low_time[15:8];
				OFF_SA_HIGH_LO: rd_data <= sa_high_time[7:0];
				OFF_SA_HIGH_HI: rd_data <= sa_high_time[15:8];
				OFF_SB_LOW_LO: rd_data <= sb_low_time[7:0];
				OFF_SB_LOW_HI: rd_data <= sb_low_time[15:8];
				OFF_SB_HIGH_LO: rd_data <= sb_high_time[7:0];
				OFF_SB_HIGH_HI: rd_data <= sb_high_time[15:8];
				OFF_GEN_CTRL: rd_data <= gen_ctrl;
				OFF_CH_CTRL: rd_data <= ch_ctrl;
				OFF_CH0_CMP_LO: rd_data <= cmp[0][7:0];
				OFF_CH0_CMP_HI: rd_data <= cmp[0][15:8];
				OFF_CH1_CMP_LO: rd_data <= cmp[1][7:0];
				OFF_CH1_CMP_HI: rd_data <= cmp[1][15:8];
				OFF_CH2_CMP_LO: rd_data <= cmp[2][7:0];
				OFF_CH2_CMP_HI: rd_data <= cmp[2][15:8];
				OFF_CH3_CMP_LO: rd_data <= cmp[3][7:0];
				OFF_CH3_CMP_HI: rd_data <= cmp[3][15:8];
				OFF_CYCLE_LO: rd_data <= cycle_value[7:0];
				OFF_CYCLE_HI: rd_data <= cycle_value[15:8];
				OFF_STATUS: rd_data <= {2'b00, single_b_out, single_a_out, quad_out};
				default: rd_data <= BYTE_RST;
			endcase
		end
	end

	// -------------------------------------------------------------
	// duty source selection
	// -------------------------------------------------------------
	always_comb begin
		eff_cmp[0] = cmp[0];
		eff_cmp[1] = duty_sel(gen_ctrl[BIT_SRC_CH1], cmp[1], cmp[0]);
		eff_cmp[2] = duty_sel(gen_ctrl[BIT_SRC_CH2], cmp[2], cmp[0]);
		eff_cmp[3] = duty_sel(gen_ctrl[BIT_SRC_CH3], cmp[3], cmp[0]);
	end

	// -------------------------------------------------------------
	// quad counter
	// -------------------------------------------------------------
	assign next_quad_cnt = {1'b0, quad_cnt} + 17'h0_0001;

	// a cycle value lowered below the count wraps at once, no long run-out
	always_ff @(posedge sys_clk) begin
		if (rst || !gen_ctrl[BIT_QUAD_EN]) begin
			quad_cnt <= WORD_RST;
		end else if (quad_cnt >= cycle_value) begin
			quad_cnt <= WORD_RST;
		end else begin
			quad_cnt <= next_quad_cnt[MCPWM_CNT_W-1:0];
		end
	end

	// -------------------------------------------------------------
	// quad outputs
	// -------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst || !gen_ctrl[BIT_QUAD_EN]) begin
			quad_out <= '0;
		end else begin
			for (int i = 0; i < MCPWM_NCH; i++) begin
				quad_out[i] <= ch_ctrl[CHEN_LSB + i]
					&& chan_level(ch_ctrl[POL_LSB + i], quad_cnt, eff_cmp[i]);
			end
		end
	end

	// -------------------------------------------------------------
	// single generators
	// -------------------------------------------------------------
	mcpwm_single u_single_a (
		.sys_clk(sys_clk),
		.rst(rst),
		.enable(gen_ctrl[BIT_SA_EN]),
		.high_time(sa_high_time),
		.low_time(sa_low_time),
		.pwm_out(sa_level)
	);

	mcpwm_single u_single_b (
		.sys_clk(sys_clk),
		.rst(rst),
		.enable(gen_ctrl[BIT_SB_EN]),
		.high_time(sb_high_time),
		.low_time(sb_low_time),
		.pwm_out(sb_level)
	);

	// one more stage puts the two single outputs a cycle behind the quad output timing
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			single_a_out <= 1'b0;
			single_b_out <= 1'b0;
		end else begin
			single_a_out <= sa_level;
			single_b_out <= sb_level;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_quad_run;
		gen_ctrl[BIT_QUAD_EN] && !req.wr;
	endsequence

	a_quad_off_low: assert property (!gen_ctrl[BIT_QUAD_EN] |=> quad_out == '0 && quad_cnt == '0)
		else $error("quad outputs active while generator disabled");
	a_single_a_off: assert property (!gen_ctrl[BIT_SA_EN] [*2] |=> !single_a_out)
		else $error("single a output active while disabled");
	a_ch1_src_ch0: assert property (s_quad_run ##0 gen_ctrl[BIT_SRC_CH1] && ch_ctrl[1]
		|=> quad_out[1] == chan_level($past(ch_ctrl[5]), $past(quad_cnt), $past(cmp[0])))
		else $error("channel 1 not following channel 0 compare");
	a_ch2_src_own: assert property (s_quad_run ##0 !gen_ctrl[BIT_SRC_CH2] && ch_ctrl[2]
		|=> quad_out[2] == chan_level($past(ch_ctrl[6]), $past(quad_cnt), $past(cmp[2])))
		else $error("channel 2 not using its own compare");
	a_ch3_src_ch0: assert property (s_quad_run ##0 gen_ctrl[BIT_SRC_CH3] && ch_ctrl[3]
		|=> quad_out[3] == chan_level($past(ch_ctrl[7]), $past(quad_cnt), $past(cmp[0])))
		else $error("channel 3 not following channel 0 compare");
	a_pol_after_pass: assert property (s_quad_run ##0 ch_ctrl[0] && quad_cnt >= cmp[0]
		|=> quad_out[0] == !$past(ch_ctrl[4]))
		else $error("channel 0 polarity after compare pass wrong");
	a_chan_gate_off: assert property (!ch_ctrl[2] |=> !quad_out[2])
		else $error("disabled channel 2 drives its output");
	a_cnt_wrap_zero: assert property (gen_ctrl[BIT_QUAD_EN] && quad_cnt >= cycle_value
		|=> quad_cnt == '0)
		else $error("quad counter failed to wrap at cycle value");
	a_cnt_step_up: assert property (s_quad_run ##0 quad_cnt < cycle_value
		|=> quad_cnt == $past(quad_cnt) + 16'h0001)
		else $error("quad counter did not step by one");
	a_cmp_write_ch1: assert property (req.wr && req.addr == OFF_CH1_CMP_HI
		|=> cmp[1][15:8] == $past(req.wdata))
		else $error("channel 1 compare high byte not stored");
	a_cycle_read_back: assert property (req.wr && req.addr == OFF_CYCLE_LO ##1 req.rd && req.addr == OFF_CYCLE_LO
		&& !req.wr |=> rd_data == $past(req.wdata, 2))
		else $error("cycle value low byte read back wrong");
	a_sb_time_store: assert property (req.wr && req.addr == OFF_SB_LOW_HI
		|=> sb_low_time[15:8] == $past(req.wdata))
		else $error("single b low time high byte not stored");
endmodule : mcpwm_top
`default_nettype wire

// ### verification/mcpwm_top_bench.sv
// Purpose: self-checking bench of the multi channel pwm unit
// Assumes: register port strobes one cycle, read data in the cycle after the read strobe
// Notes: duty is judged by counting high cycles over whole periods, so counter phase does not matter
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module mcpwm_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import mcpwm_pkg::*;

	logic sys_clk;
	logic rst;
	mcpwm_req_t req;
	logic [7:0] rd_data;
	logic [3:0] quad_out;
	logic single_a_out;
	logic single_b_out;
	int fails;
	int cmp_count;
	// four-state counts, so an unknown output level cannot pass as low
	integer cnt [6];
	logic [7:0] rv;
	logic [7:0] offs [20] = '{OFF_SA_LOW_LO, OFF_SA_LOW_HI, OFF_SA_HIGH_LO, OFF_SA_HIGH_HI, OFF_SB_LOW_LO,
		OFF_SB_LOW_HI, OFF_SB_HIGH_LO, OFF_SB_HIGH_HI, OFF_GEN_CTRL, OFF_CH_CTRL, OFF_CH0_CMP_LO, OFF_CH0_CMP_HI,
		OFF_CH1_CMP_LO, OFF_CH1_CMP_HI, OFF_CH2_CMP_LO, OFF_CH2_CMP_HI, OFF_CH3_CMP_LO, OFF_CH3_CMP_HI,
		OFF_CYCLE_LO, OFF_CYCLE_HI};

	mcpwm_top dut (
		.sys_clk(sys_clk),
		.rst(rst),
		.req(req),
		.rd_data(rd_data),
		.quad_out(quad_out),
		.single_a_out(single_a_out),
		.single_b_out(single_b_out)
	);

	// -------------------------------------------------------------
	// clock, watchdog
	// -------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	initial begin
		#500000;
		fails++;
		close_out();
	end

	// -------------------------------------------------------------
	// register port and sampling tasks
	// -------------------------------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		req <= '0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk);
		req <= '0;
		#1;
		d = rd_data;
	endtask : rd_reg

	// settle first so the output stage lag and any old phase have drained
	task automatic run_count(input int settle, input int n);
		logic [5:0] s;
		repeat (settle) @(posedge sys_clk);
		foreach (cnt[i]) cnt[i] = 0;
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			s = {single_b_out, single_a_out, quad_out};
			for (int i = 0; i < 6; i++) cnt[i] += s[i];
		end
	endtask : run_count

	task automatic exp6(input int e [6]);
		for (int i = 0; i < 6; i++) `CHK(cnt[i], e[i])
	endtask : exp6

	// -------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------
	task automatic test_regs();
		foreach (offs[i]) begin
			rd_reg(offs[i], rv);
			`CHK(rv, BYTE_RST)
		end
		foreach (offs[i]) begin
			wr_reg(offs[i], 8'hff);
			rd_reg(offs[i], rv);
			`CHK(rv, (offs[i] == OFF_GEN_CTRL) ? 8'h3f : 8'hff)
			wr_reg(offs[i], 8'h00);
		end
		wr_reg(8'ha8, 8'h55);
		rd_reg(8'ha8, rv);
		`CHK(rv, 8'h00)
		@(posedge sys_clk);
		#1;
		`CHK(rd_data, 8'h00)
		// back to back write then read, no idle cycle between the strobes
		@(posedge sys_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: OFF_CYCLE_LO, wdata: 8'h5a};
		@(posedge sys_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: OFF_CYCLE_LO, wdata: 8'h00};
		@(posedge sys_clk);
		req <= '0;
		#1;
		`CHK(rd_data, 8'h5a)
		@(posedge sys_clk);
		#1;
		`CHK(rd_data, 8'h00)
		wr_reg(OFF_CYCLE_LO, 8'h00);
		$display("test_regs done");
	endtask : test_regs

	task automatic test_quad();
		wr_reg(OFF_CYCLE_LO, 8'h07);
		wr_reg(OFF_CH0_CMP_LO, 8'h01);
		wr_reg(OFF_CH1_CMP_LO, 8'h02);
		wr_reg(OFF_CH2_CMP_LO, 8'h03);
		wr_reg(OFF_CH3_CMP_LO, 8'h05);
		wr_reg(OFF_CH_CTRL, 8'h0f);
		wr_reg(OFF_GEN_CTRL, 8'h01);
		run_count(20, 16);
		exp6('{14, 12, 10, 6, 0, 0});
		wr_reg(OFF_CH_CTRL, 8'hff);
		run_count(4, 16);
		exp6('{2, 4, 6, 10, 0, 0});
		wr_reg(OFF_CH_CTRL, 8'h0f);
		wr_reg(OFF_GEN_CTRL, 8'h39);
		run_count(4, 16);
		exp6('{14, 14, 14, 14, 0, 0});
		wr_reg(OFF_GEN_CTRL, 8'h09);
		run_count(4, 16);
		exp6('{14, 14, 10, 6, 0, 0});
		wr_reg(OFF_GEN_CTRL, 8'h01);
		wr_reg(OFF_CH3_CMP_HI, 8'h01);
		wr_reg(OFF_CH_CTRL, 8'h8f);
		run_count(4, 16);
		exp6('{14, 12, 10, 16, 0, 0});
		wr_reg(OFF_CH_CTRL, 8'h05);
		run_count(4, 16);
		exp6('{14, 0, 10, 0, 0, 0});
		wr_reg(OFF_GEN_CTRL, 8'h00);
		run_count(4, 16);
		exp6('{0, 0, 0, 0, 0, 0});
		$display("test_quad done");
	endtask : test_quad

	task automatic test_single();
		wr_reg(OFF_SB_HIGH_LO, 8'h02);
		wr_reg(OFF_SB_LOW_LO, 8'h01);
		wr_reg(OFF_SA_HIGH_LO, 8'h03);
		wr_reg(OFF_SA_LOW_LO, 8'h05);
		wr_reg(OFF_GEN_CTRL, 8'h04);
		run_count(6, 24);
		exp6('{0, 0, 0, 0, 0, 16});
		wr_reg(OFF_GEN_CTRL, 8'h06);
		run_count(6, 48);
		exp6('{0, 0, 0, 0, 18, 32});
		wr_reg(OFF_SB_HIGH_LO, 8'h00);
		wr_reg(OFF_SB_HIGH_HI, 8'h01);
		wr_reg(OFF_SA_HIGH_LO, 8'h01);
		wr_reg(OFF_SA_LOW_HI, 8'h01);
		wr_reg(OFF_SA_LOW_LO, 8'h00);
		run_count(600, 1542);
		exp6('{0, 0, 0, 0, 6, 1536});
		// zero low time gives a steady high, zero high time a steady low
		wr_reg(OFF_GEN_CTRL, 8'h04);
		wr_reg(OFF_SB_LOW_LO, 8'h00);
		run_count(6, 20);
		exp6('{0, 0, 0, 0, 0, 20});
		rd_reg(OFF_STATUS, rv);
		`CHK(rv, 8'h20)
		wr_reg(OFF_SB_HIGH_HI, 8'h00);
		run_count(6, 20);
		exp6('{0, 0, 0, 0, 0, 0});
		wr_reg(OFF_GEN_CTRL, 8'h00);
		run_count(4, 20);
		exp6('{0, 0, 0, 0, 0, 0});
		$display("test_single done");
	endtask : test_single

	// second reset in mid-run must clear settings and outputs again
	task automatic test_rerst();
		wr_reg(OFF_GEN_CTRL, 8'h07);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		`CHK({single_b_out, single_a_out, quad_out}, 6'h00)
		rd_reg(OFF_GEN_CTRL, rv);
		`CHK(rv, BYTE_RST)
		rd_reg(OFF_SA_LOW_HI, rv);
		`CHK(rv, BYTE_RST)
		run_count(2, 10);
		exp6('{0, 0, 0, 0, 0, 0});
		$display("test_rerst done");
	endtask : test_rerst

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		fails = 0;
		cmp_count = 0;
		rst = 1'b1;
		req = '0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		test_regs();
		test_quad();
		test_single();
		test_rerst();
		close_out();
	end
endmodule : mcpwm_top_bench
`default_nettype wire
